//--- core/tlic_top.sv
`timescale 1ns/1ps
// How it works
// - High vector is 0008h, low vector is 0018h.
// - Enabled high request preempts a low service in progress.
// - Every source has a flag, an enable and a priority bit.
// - Priority mode bit clear at reset; priority bits are then ignored.
// - Compatibility mode: peripheral sources need peripheral and main enable.
// - Compatibility mode: main enable gates every source.
// - Compatibility mode: all interrupts vector to 0008h.
// - Priority mode: global enables become high and low level enables.
// - Priority mode: clear high enable blocks every source.
// - Priority mode: low sources need low and high enable.
// - Priority mode: flag, enable and global enable set vectors by priority bit.
// - Vectoring clears the applicable global enable.
// - No low request is taken during high service.
// - Vectoring pushes the return address and loads the vector.
// - Return from interrupt leaves service and sets the enable again.
// - Pin events reach vectoring in three to four instruction cycles.
// - Flags set on events regardless of any enable.
// - A clear source enable stops vectoring but keeps the flag working.
module tlic_top #(
	parameter int NSRC = 8
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                clk_en,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic [NSRC-1:0]     src_event,
	input  wire logic [NSRC-1:0]     src_is_pin,
	input  wire logic [15:0]         core_pc,
	input  wire logic                return_from_interrupt_instr,
	output tlic_pkg::tlic_vec_type   vec_out,
	output logic                     stack_push,
	output logic      [15:0]         stack_data
);
	import tlic_pkg::*;

	// Elaboration refuses source counts that one 32-bit register word cannot carry.
	if (NSRC < 1 || NSRC > 32)
	begin : g_bad_nsrc
		$error("NSRC must lie between 1 and 32.");
	end

	logic [NSRC-1:0] flag_r;
	logic [NSRC-1:0] en_r;
	logic [NSRC-1:0] prio_r;
	logic [NSRC-1:0] peri_r;
	logic            main_ge_r;
	logic            peri_ge_r;
	logic            prio_mode_r;
	logic            hi_act_r;
	logic            lo_act_r;
	logic [NSRC-1:0] ev_s1_r;
	logic [NSRC-1:0] ev_s2_r;
	logic [NSRC-1:0] ev_d_r;
	logic [7:0]      lat_cnt_r;
	logic            wr_acc;
	logic            rd_acc;
	logic [NSRC-1:0] ev_pulse;
	logic [NSRC-1:0] active;
	logic [NSRC-1:0] eligible_hi;
	logic [NSRC-1:0] eligible_lo;
	logic            take_hi;
	logic            take_lo;
	logic            take;

	// Zero wait states, so pready is a constant high handshake.
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign wr_acc  = psel && penable && pwrite && clk_en;
	assign rd_acc  = psel && !penable && !pwrite;

	// Event inputs come from other logic or pins, so they are synchronised first.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ev_s1_r <= '0;
			ev_s2_r <= '0;
			ev_d_r  <= '0;
		end
		else if (clk_en)
		begin
			ev_s1_r <= src_event;
			ev_s2_r <= ev_s1_r;
			ev_d_r  <= ev_s2_r;
		end
	end

	assign ev_pulse = ev_s2_r & ~ev_d_r;

	// Flags set on any event whatever the enables; a set beats a software clear.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag_r <= '0;
		else if (clk_en)
		begin
			if (wr_acc && paddr == OFF_FLAG)
				flag_r <= pwdata[NSRC-1:0] | ev_pulse;
			else
				flag_r <= flag_r | ev_pulse;
		end
	end

	// Per-source enable, priority and peripheral class bits.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			en_r   <= '0;
			prio_r <= {NSRC{PRIO_RST[0]}}; // Every source starts at high level.
			peri_r <= '0;
		end
		else if (wr_acc)
		begin
			if (paddr == OFF_EN)
				en_r <= pwdata[NSRC-1:0];
			if (paddr == OFF_PRIO)
				prio_r <= pwdata[NSRC-1:0];
			if (paddr == OFF_PERI)
				peri_r <= pwdata[NSRC-1:0];
		end
	end

	// Pin-sourced flags wait out a fixed latency so one- and two-cycle
	// instructions see the same delay.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lat_cnt_r <= '0;
		end
		else if (clk_en)
		begin
			if (|(ev_pulse & src_is_pin))
				lat_cnt_r <= 8'(LAT_CLKS - 3);
			else if (lat_cnt_r != 8'h00)
				lat_cnt_r <= lat_cnt_r - 8'h01;
		end
	end

	// A pin flag is visible to the request logic only once the latency ran out.
	assign active = flag_r & en_r & (lat_cnt_r == 8'h00 ? flag_r : ~src_is_pin);

	// Eligibility per level, for both modes.
	always_comb
	begin
		eligible_hi = '0;
		eligible_lo = '0;
		if (!prio_mode_r)
		begin
			// Priority bits are ignored in compatibility mode.
			eligible_hi = active & (peri_r & {NSRC{peri_ge_r && main_ge_r}}
			            | ~peri_r & {NSRC{main_ge_r}});
		end
		else
		begin
			eligible_hi = active & prio_r & {NSRC{main_ge_r}};
			eligible_lo = active & ~prio_r & {NSRC{peri_ge_r && main_ge_r}};
		end
	end

	// High wins a tie; low is held off during high service.
	assign take_hi = |eligible_hi && !hi_act_r;
	assign take_lo = |eligible_lo && !hi_act_r && !lo_act_r && !take_hi;
	assign take    = take_hi || take_lo;

	// Global enables: software writes them, vectoring clears, return sets.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			main_ge_r   <= CTRL_RST[CTRL_MAIN];
			peri_ge_r   <= CTRL_RST[CTRL_PERI];
			prio_mode_r <= CTRL_RST[CTRL_PMOD];
		end
		else if (clk_en)
		begin
			if (wr_acc && paddr == OFF_CTRL)
			begin
				main_ge_r   <= pwdata[CTRL_MAIN];
				peri_ge_r   <= pwdata[CTRL_PERI];
				prio_mode_r <= pwdata[CTRL_PMOD];
			end
			else if (take_hi)
				main_ge_r <= 1'b0;
			else if (take_lo)
				peri_ge_r <= 1'b0;
			else if (return_from_interrupt_instr)
			begin
				if (!prio_mode_r || hi_act_r)
					main_ge_r <= 1'b1;
				else
					peri_ge_r <= 1'b1;
			end
		end
	end

	// Service record; a return closes the most recent level first.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hi_act_r <= 1'b0;
			lo_act_r <= 1'b0;
		end
		else if (clk_en)
		begin
			if (take_hi)
				hi_act_r <= 1'b1;
			else if (take_lo)
				lo_act_r <= 1'b1;
			else if (return_from_interrupt_instr)
			begin
				if (hi_act_r)
					hi_act_r <= 1'b0;
				else
					lo_act_r <= 1'b0;
			end
		end
	end

	// Vector request, return address push, registered for one cycle.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			vec_out    <= '0;
			stack_push <= 1'b0;
			stack_data <= '0;
		end
		else if (clk_en)
		begin
			vec_out.valid <= take;
			vec_out.high  <= take_hi;
			vec_out.addr  <= take_lo ? VEC_LOW : VEC_HIGH;
			stack_push    <= take;
			stack_data    <= core_pc;
		end
	end

	// Read data is registered during setup, valid in the access phase.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= '0;
		else if (rd_acc && clk_en)
		begin
			unique case (paddr)
				OFF_CTRL: prdata <= {29'h0, prio_mode_r, peri_ge_r, main_ge_r};
				OFF_FLAG: prdata <= 32'(flag_r);
				OFF_EN:   prdata <= 32'(en_r);
				OFF_PRIO: prdata <= 32'(prio_r);
				OFF_PERI: prdata <= 32'(peri_r);
				OFF_STAT: prdata <= {30'h0, lo_act_r, hi_act_r};
				default:  prdata <= 32'h0;
			endcase
		end
	end

	// Helper sequences for the vectoring checks.
	sequence s_take_high;
		take_hi && clk_en;
	endsequence

	sequence s_vec_high;
		vec_out.valid && vec_out.addr == 16'h0008 && stack_push;
	endsequence

	a_high_vector_addr: assert property (@(posedge pclk) disable iff (!presetn)
		s_take_high |=> s_vec_high)
		else $error("High request did not vector to 0008h.");

	a_low_vector_addr: assert property (@(posedge pclk) disable iff (!presetn)
		take_lo && clk_en |=> vec_out.valid && vec_out.addr == 16'h0018)
		else $error("Low request did not vector to 0018h.");

	a_compat_single_vec: assert property (@(posedge pclk) disable iff (!presetn)
		!prio_mode_r && take |-> take_hi)
		else $error("Compatibility mode took a low vector.");

	a_no_low_in_high: assert property (@(posedge pclk) disable iff (!presetn)
		hi_act_r |-> !take_lo)
		else $error("Low request taken during high service.");

	a_enable_cleared: assert property (@(posedge pclk) disable iff (!presetn)
		take_hi && clk_en && !(wr_acc && paddr == OFF_CTRL) |=> !main_ge_r)
		else $error("Main enable not cleared on vectoring.");

	a_flag_sets_event: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && |ev_pulse |=> (flag_r & $past(ev_pulse)) == $past(ev_pulse))
		else $error("Event did not set its flag.");

	a_disabled_src: assert property (@(posedge pclk) disable iff (!presetn)
		en_r == '0 |-> !take)
		else $error("Disabled sources caused vectoring.");

	a_high_preempts: assert property (@(posedge pclk) disable iff (!presetn)
		lo_act_r && !hi_act_r && |eligible_hi |-> take_hi)
		else $error("High request failed to preempt low service.");

	a_tie_high_first: assert property (@(posedge pclk) disable iff (!presetn)
		|eligible_hi && |eligible_lo && !hi_act_r |-> take_hi && !take_lo)
		else $error("Tie not resolved toward high priority.");

	// Return steps leave out a take or a control write in the same cycle, since both outrank it.
	sequence s_ret_main;
		return_from_interrupt_instr && clk_en && !take && !(wr_acc && paddr == OFF_CTRL)
			&& (!prio_mode_r || hi_act_r);
	endsequence

	sequence s_ret_low;
		return_from_interrupt_instr && clk_en && !take && !(wr_acc && paddr == OFF_CTRL)
			&& prio_mode_r && !hi_act_r;
	endsequence

	a_return_main: assert property (@(posedge pclk) disable iff (!presetn)
		s_ret_main |=> main_ge_r)
		else $error("Return did not restore the main enable.");

	a_return_low: assert property (@(posedge pclk) disable iff (!presetn)
		s_ret_low |=> peri_ge_r && !lo_act_r)
		else $error("Return did not restore the low level enable.");

	a_record_high: assert property (@(posedge pclk) disable iff (!presetn)
		s_take_high |=> hi_act_r)
		else $error("High service was not recorded.");

	a_push_return: assert property (@(posedge pclk) disable iff (!presetn)
		take && clk_en |=> stack_push && stack_data == $past(core_pc))
		else $error("Return address was not pushed with the vector.");

	a_high_off_blocks: assert property (@(posedge pclk) disable iff (!presetn)
		prio_mode_r && !main_ge_r |-> !take)
		else $error("Vectoring while the high level enable was clear.");

	// A low clock enable must leave every piece of state untouched, vector output included.
	a_state_frozen: assert property (@(posedge pclk) disable iff (!presetn)
		!clk_en |=> $stable(flag_r) && $stable(main_ge_r) && $stable(peri_ge_r)
			&& $stable(hi_act_r) && $stable(lo_act_r) && $stable(vec_out))
		else $error("State changed while the clock enable was low.");

endmodule : tlic_top

//--- core/tlic_pkg.sv
package tlic_pkg;

	// Vector addresses.
	localparam logic [15:0] VEC_HIGH = 16'h0008;
	localparam logic [15:0] VEC_LOW  = 16'h0018;

	// Register byte offsets.
	localparam logic [11:0] OFF_CTRL  = 12'h000;
	localparam logic [11:0] OFF_FLAG  = 12'h004;
	localparam logic [11:0] OFF_EN    = 12'h008;
	localparam logic [11:0] OFF_PRIO  = 12'h00c;
	localparam logic [11:0] OFF_PERI  = 12'h010;
	localparam logic [11:0] OFF_STAT  = 12'h014;

	// Control register bit positions.
	localparam int CTRL_MAIN = 0;
	localparam int CTRL_PERI = 1;
	localparam int CTRL_PMOD = 2;

	// Reset values.
	localparam logic [2:0]  CTRL_RST = 3'h0;
	localparam logic [7:0]  PRIO_RST = 8'hff;

	// Latency in instruction cycles from event to vector request.
	localparam int LAT_INSTR = 3;
	localparam int INSTR_CLKS = 4;
	localparam int LAT_CLKS = LAT_INSTR * INSTR_CLKS;

	// Vector request toward the core.
	typedef struct packed {
		logic        valid;
		logic        high;
		logic [15:0] addr;
	} tlic_vec_type;

endpackage : tlic_pkg

//--- tb/tlic_core_model.sv
`timescale 1ns/1ps
// Behavioural core: counts the program counter, jumps on a vector, checks each push.
module tlic_core_model (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire tlic_pkg::tlic_vec_type vec_out,
	input  wire logic                   stack_push,
	input  wire logic [15:0]            stack_data,
	input  wire logic                   ret_go,
	output logic      [15:0]            core_pc,
	output logic                        rfi,
	output int                          stack_bad
);
	import tlic_pkg::*;

	// The pushed address is the count of the take cycle, one behind the present count.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			core_pc   <= 16'h0100;
			stack_bad <= 0;
		end
		else
		begin
			if (stack_push !== vec_out.valid)
				stack_bad <= stack_bad + 1;
			else if (stack_push && stack_data !== core_pc - 16'h0001)
				stack_bad <= stack_bad + 1;
			core_pc <= vec_out.valid ? vec_out.addr : core_pc + 16'h0001;
		end
	end

	// The return strobe lasts one cycle, as a real core issues it.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			rfi <= 1'b0;
		else
			rfi <= ret_go;
	end
endmodule : tlic_core_model

//--- tb/tb.sv
`timescale 1ns/1ps
// Bench: APB register access, source events and vector checks beside a core model.
module tb;
	import tlic_pkg::*;
	logic          pclk = 1'b0;
	logic          presetn = 1'b0;
	logic          psel = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	logic [11:0]   paddr = 12'h000;
	logic [31:0]   pwdata = 32'h0;
	logic [31:0]   prdata;
	logic          pready;
	logic [7:0]    src_event = 8'h00;
	logic [15:0]   core_pc;
	logic          rfi;
	logic          ret_go = 1'b0;
	logic          clk_en = 1'b1;
	logic          pslverr;
	logic          stack_push;
	logic [15:0]   stack_data;
	tlic_vec_type  vec_out;
	int            stack_bad;
	int            n;
	int            error_cnt = 0;
	int            total_checks = 0;

	always #5 pclk = ~pclk;

	tlic_top #(.NSRC(8)) tlic_top_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .src_event(src_event),
		.src_is_pin(8'h08), .core_pc(core_pc), .return_from_interrupt_instr(rfi),
		.vec_out(vec_out), .stack_push(stack_push), .stack_data(stack_data));
	tlic_core_model tlic_core_model_i (.pclk(pclk), .presetn(presetn), .vec_out(vec_out),
		.stack_push(stack_push), .stack_data(stack_data), .ret_go(ret_go),
		.core_pc(core_pc), .rfi(rfi), .stack_bad(stack_bad));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		q = prdata;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		chk(nm, e, q);
	endtask : rd

	// The line drops for a cycle first so that every call makes a fresh rising edge.
	task automatic ev(input logic [7:0] m);
		@(posedge pclk);
		src_event <= 8'h00;
		@(posedge pclk);
		src_event <= m;
	endtask : ev

	task automatic wait_vec(input logic [15:0] a);
		n = 0;
		do
		begin
			@(posedge pclk);
			#1;
			n++;
		end
		while (vec_out.valid !== 1'b1 && n < 40);
		chk("vector seen", 32'h1, {31'h0, vec_out.valid});
		chk("vector address", {16'h0, a}, {16'h0, vec_out.addr});
		chk("vector level", {31'h0, a == VEC_HIGH}, {31'h0, vec_out.high});
	endtask : wait_vec

	task automatic no_vec;
		logic seen;
		seen = 1'b0;
		repeat (24)
		begin
			@(posedge pclk);
			#1;
			if (vec_out.valid === 1'b1)
				seen = 1'b1;
		end
		chk("no vector", 32'h0, {31'h0, seen});
	endtask : no_vec

	task automatic ret;
		@(posedge pclk);
		ret_go <= 1'b1;
		@(posedge pclk);
		ret_go <= 1'b0; // A pending request may vector two edges on; callers must not miss it.
	endtask : ret

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : results

	// A hang ends the run the same way as the main sequence.
	initial
	begin
		#100000;
		error_cnt++;
		results();
	end

	// Main sequence: reset values, compatibility mode, priority mode, pin latency.
	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_CTRL, 32'h0, "ctrl reset");
		rd(OFF_PRIO, 32'hff, "prio reset");
		wr(12'h018, 32'hffffffff);
		rd(12'h018, 32'h0, "unmapped");
		chk("slave error", 32'h0, {31'h0, pslverr});
		$display("test reset done");
		wr(OFF_EN, 32'h0f);
		wr(OFF_PRIO, 32'h00);
		wr(OFF_PERI, 32'h02);
		ev(8'h01);
		no_vec();
		rd(OFF_FLAG, 32'h01, "flag polled");
		wr(OFF_CTRL, 32'h1);
		wait_vec(16'h0008);
		rd(OFF_CTRL, 32'h0, "main cleared");
		wr(OFF_FLAG, 32'h0);
		ret();
		rd(OFF_CTRL, 32'h1, "main restored");
		ev(8'h02);
		no_vec();
		wr(OFF_CTRL, 32'h3);
		wait_vec(16'h0008);
		rd(OFF_CTRL, 32'h2, "peri main cleared");
		wr(OFF_FLAG, 32'h0);
		ret();
		wr(OFF_EN, 32'h0e);
		ev(8'h01);
		no_vec();
		rd(OFF_FLAG, 32'h01, "flag kept");
		wr(OFF_FLAG, 32'h0);
		wr(OFF_EN, 32'h0f);
		$display("test compat done");
		wr(OFF_CTRL, 32'h4);
		wr(OFF_PRIO, 32'h0c);
		wr(OFF_CTRL, 32'h5);
		ev(8'h01);
		no_vec();
		wr(OFF_CTRL, 32'h7);
		wait_vec(16'h0018);
		rd(OFF_CTRL, 32'h5, "low cleared");
		rd(OFF_STAT, 32'h2, "low active");
		ev(8'h04);
		wait_vec(16'h0008);
		rd(OFF_CTRL, 32'h4, "high cleared");
		rd(OFF_STAT, 32'h3, "both active");
		wr(OFF_FLAG, 32'h01);
		wr(OFF_CTRL, 32'h7);
		no_vec();
		wr(OFF_FLAG, 32'h0);
		ret();
		rd(OFF_STAT, 32'h2, "high left first");
		ret();
		rd(OFF_STAT, 32'h0, "none active");
		wr(OFF_CTRL, 32'h6);
		ev(8'h01);
		no_vec();
		wr(OFF_FLAG, 32'h0);
		wr(OFF_CTRL, 32'h7);
		ev(8'h05);
		wait_vec(16'h0008);
		wr(OFF_FLAG, 32'h01);
		ret();
		wait_vec(16'h0018);
		wr(OFF_FLAG, 32'h0);
		ret();
		$display("test priority done");
		repeat (2) @(posedge pclk);
		clk_en <= 1'b0;
		ev(8'h02);
		no_vec();
		@(posedge pclk);
		clk_en <= 1'b1;
		wait_vec(16'h0018);
		wr(OFF_FLAG, 32'h0);
		ret();
		$display("test freeze done");
		ev(8'h08);
		wait_vec(16'h0008);
		chk("pin latency", 32'h1, {31'h0, (n >= 12 && n <= 16)});
		chk("stack pushes", 32'h0, stack_bad);
		$display("test latency done");
		results();
	end
endmodule : tb
